// ===== logic/flash_pkg.sv
// Shared constants for the flash mode select and protection block.
// Assumes a 32-bit AHB-Lite register window and word-wide array storage.
package flash_pkg;

  // ------------------------------------------------------------
  // Array geometry
  // ------------------------------------------------------------
  localparam int unsigned FLASH_BYTES = 262144;
  localparam int unsigned BLOCK_BYTES = 131072;
  localparam int unsigned NUM_BLOCKS = 2;
  localparam int unsigned FLASH_WORDS = FLASH_BYTES / 4;
  localparam int unsigned WIDX_W = 16;
  localparam int unsigned WIDX_LSB = 2;
  localparam int unsigned WIDX_MSB = 17;
  localparam int unsigned BLK_BIT_WIDX = 15;
  localparam int unsigned PRG_ADDR_W = 17;
  localparam logic [31:0] FLASH_LIMIT = 32'h0004_0000;
  localparam logic [WIDX_W-1:0] LAST_WIDX = 16'hffff;
  localparam logic [31:0] ERASED_WORD = 32'hffff_ffff;

  // ------------------------------------------------------------
  // Register window
  // ------------------------------------------------------------
  localparam logic [23:0] REG_PAGE = 24'h000400;
  localparam logic [7:0] OFF_KEY = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_ADDR = 8'h08;
  localparam logic [7:0] OFF_DATA = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_PROT = 8'h14;
  localparam logic [7:0] OFF_MODE = 8'h18;
  // Unlock value is arbitrary
  localparam logic [31:0] UNLOCK_KEY = 32'h0000_5a5a;

  // Status and protection register bit positions
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_TOGGLE = 1;
  localparam int unsigned ST_DONE = 2;
  localparam int unsigned ST_ERR = 3;
  localparam int unsigned PROT_LOCK = 2;

  // ------------------------------------------------------------
  // Commands, modes, sequencer states
  // ------------------------------------------------------------
  localparam logic [3:0] CMD_PROGRAM = 4'h1;
  localparam logic [3:0] CMD_CHIP_ERASE = 4'h2;
  localparam logic [3:0] CMD_BLOCK_ERASE = 4'h3;
  localparam logic [3:0] CMD_MULTI_ERASE = 4'h4;
  localparam logic [3:0] CMD_PROTECT = 4'h5;
  localparam logic [3:0] CMD_UNPROTECT = 4'h6;

  typedef enum logic [1:0] {
    MODE_NONE = 2'b00,
    MODE_SINGLE_CHIP = 2'b01,
    MODE_SINGLE_BOOT = 2'b11,
    MODE_PROGRAMMER = 2'b10
  } mode_e;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_PROG = 2'b01,
    S_ERASE = 2'b11,
    S_UNPROT = 2'b10
  } seq_e;

endpackage

// ===== logic/block_guard.sv
// One block's protection cell.
// Assumes nvm_init_in is pulsed only at manufacture or bench start.
`timescale 1ns/1ps
module block_guard #(
  parameter logic INIT_PROT = 1'b0
) (
  // Clock and cell initialise
  input wire logic clk_in,
  input wire logic nvm_init_in,
  // Set and clear strobes
  input wire logic set_in,
  input wire logic clr_in,
  // State
  output logic prot_out
);

  logic prot_q;

  // Not cleared by system reset: the bit models a non-volatile cell
  always_ff @(posedge clk_in)
  begin
    if (nvm_init_in)
      prot_q <= INIT_PROT;
    else if (set_in)
      prot_q <= 1'b1;
    else if (clr_in)
      prot_q <= 1'b0;
  end

  assign prot_out = prot_q;

endmodule

// ===== logic/mode_latch.sv
// Strap decoder that fixes the operating mode at reset release.
// Assumes straps synchronous to the clock and reset active high.
`timescale 1ns/1ps
module mode_latch (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Straps
  input wire logic boot_strap_port_pin_in,
  input wire logic test_strap_first_in,
  input wire logic test_strap_second_in,
  input wire logic [3:0] mode_strap_in,
  // Mode
  output flash_pkg::mode_e mode_out,
  output logic programmer_out,
  output logic pins_free_out
);

  flash_pkg::mode_e cap_q;
  flash_pkg::mode_e mode_q;
  logic rel_q;

  wire tests_low = ~test_strap_first_in & ~test_strap_second_in;
  wire chip_sel = boot_strap_port_pin_in & tests_low;
  wire boot_sel = ~boot_strap_port_pin_in & tests_low;
  // Port straps a..d map to bits 0..3
  wire prog_sel = (mode_strap_in == 4'h3) & test_strap_first_in & ~test_strap_second_in;

  // Programmer mode lives only while reset is held
  assign programmer_out = rst_in & prog_sel;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      cap_q <= chip_sel ? flash_pkg::MODE_SINGLE_CHIP :
               boot_sel ? flash_pkg::MODE_SINGLE_BOOT : flash_pkg::MODE_NONE;
      mode_q <= flash_pkg::MODE_NONE;
      rel_q <= 1'b0;
    end
    else if (!rel_q)
    begin
      mode_q <= cap_q;
      rel_q <= 1'b1;
    end
  end

  assign mode_out = mode_q;
  assign pins_free_out = rel_q;

endmodule

// ===== logic/flash_mode_select_protect.sv
// Flash array with command sequencer, block protection and mode capture.
// Assumes a single AHB-Lite master doing whole-word single transfers.
//
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module flash_mode_select_protect (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic NVM_INIT_IN,
  // AHB-Lite slave
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  // Mode straps
  input wire logic BOOT_STRAP_PORT_PIN_IN,
  input wire logic TEST_STRAP_FIRST_IN,
  input wire logic TEST_STRAP_SECOND_IN,
  input wire logic MODE_STRAP_A_IN,
  input wire logic MODE_STRAP_B_IN,
  input wire logic MODE_STRAP_C_IN,
  input wire logic MODE_STRAP_D_IN,
  // Programmer port
  input wire logic PRG_RD_IN,
  input wire logic [flash_pkg::PRG_ADDR_W-1:0] PRG_ADDR_IN,
  output logic [15:0] PRG_DATA_OUT,
  // Mode and protection status
  output logic CORE_RUN_OUT,
  output logic BOOT_ROM_SEL_OUT,
  output logic FLASH_AT_VECTOR_OUT,
  output logic PROGRAMMER_MODE_OUT,
  output logic MODE_INVALID_OUT,
  output logic STRAP_PINS_FREE_OUT,
  output logic [flash_pkg::NUM_BLOCKS-1:0] PROT_OUT,
  output logic PRG_LOCK_OUT
);

  // ------------------------------------------------------------
  // Storage and state
  // ------------------------------------------------------------
  logic [31:0] mem [0:flash_pkg::FLASH_WORDS-1];
  flash_pkg::seq_e state_q;
  flash_pkg::seq_e state_d;
  flash_pkg::mode_e mode;
  logic [flash_pkg::WIDX_W-1:0] ctr_q;
  logic [flash_pkg::WIDX_W-1:0] ctr_d;
  logic [flash_pkg::NUM_BLOCKS-1:0] mask_q;
  logic [flash_pkg::NUM_BLOCKS-1:0] mask_d;
  logic [flash_pkg::NUM_BLOCKS-1:0] prot;
  logic [flash_pkg::NUM_BLOCKS-1:0] prot_set;
  logic [flash_pkg::NUM_BLOCKS-1:0] prot_clr;
  logic [31:0] addr_q;
  logic [31:0] data_q;
  logic [31:0] rdata_q;
  logic [15:0] prg_data_q;
  logic armed_q;
  logic done_q;
  logic err_q;
  logic toggle_q;
  logic wr_pend_q;
  logic [7:0] wr_off_q;
  logic done_set;
  logic err_set;
  logic mem_we;
  logic [flash_pkg::WIDX_W-1:0] mem_idx;
  logic [31:0] mem_wdata;
  logic programmer;
  logic pins_free;

  // ------------------------------------------------------------
  // Mode capture and protection cells
  // ------------------------------------------------------------
  mode_latch u_mode (
    .clk_in(REF_CLK_IN),
    .rst_in(SYS_RST_IN),
    .boot_strap_port_pin_in(BOOT_STRAP_PORT_PIN_IN),
    .test_strap_first_in(TEST_STRAP_FIRST_IN),
    .test_strap_second_in(TEST_STRAP_SECOND_IN),
    .mode_strap_in({MODE_STRAP_D_IN, MODE_STRAP_C_IN, MODE_STRAP_B_IN, MODE_STRAP_A_IN}),
    .mode_out(mode),
    .programmer_out(programmer),
    .pins_free_out(pins_free)
  );

  for (genvar b = 0; b < flash_pkg::NUM_BLOCKS; b++)
  begin : g_guard
    block_guard u_guard (
      .clk_in(REF_CLK_IN),
      .nvm_init_in(NVM_INIT_IN),
      .set_in(prot_set[b]),
      .clr_in(prot_clr[b]),
      .prot_out(prot[b])
    );
  end

  wire lock = &prot;
  wire busy = (state_q != flash_pkg::S_IDLE);

  // ------------------------------------------------------------
  // AHB-Lite decode
  // ------------------------------------------------------------
  wire ap_valid = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
  wire ap_regs = (HADDR_IN[31:8] == flash_pkg::REG_PAGE);
  wire ap_flash = (HADDR_IN < flash_pkg::FLASH_LIMIT);
  wire [7:0] ap_off = HADDR_IN[7:0];
  wire [flash_pkg::WIDX_W-1:0] ap_widx = HADDR_IN[flash_pkg::WIDX_MSB:flash_pkg::WIDX_LSB];
  wire ap_read = ap_valid & ~HWRITE_IN;
  wire ap_write = ap_valid & HWRITE_IN & ap_regs;

  wire wr_key = wr_pend_q & (wr_off_q == flash_pkg::OFF_KEY);
  wire wr_cmd = wr_pend_q & (wr_off_q == flash_pkg::OFF_CMD);
  wire wr_addr = wr_pend_q & (wr_off_q == flash_pkg::OFF_ADDR);
  wire wr_data = wr_pend_q & (wr_off_q == flash_pkg::OFF_DATA);
  wire wr_stat = wr_pend_q & (wr_off_q == flash_pkg::OFF_STATUS);
  wire [3:0] cmd_code = HWDATA_IN[3:0];
  // Only an armed command write starts work; nothing else touches the array
  wire cmd_go = wr_cmd & armed_q & ~busy;

  wire [31:0] status_word = {28'h0000000, err_q, done_q, toggle_q & busy, busy};
  wire [31:0] prot_word = {29'h00000000, lock, prot};
  wire [31:0] mode_word = {30'h00000000, mode};
  wire [31:0] reg_rd =
    (ap_off == flash_pkg::OFF_ADDR) ? addr_q :
    (ap_off == flash_pkg::OFF_DATA) ? data_q :
    (ap_off == flash_pkg::OFF_STATUS) ? status_word :
    (ap_off == flash_pkg::OFF_PROT) ? prot_word :
    (ap_off == flash_pkg::OFF_MODE) ? mode_word : 32'h0000_0000;
  // Full-word array read on the core side
  wire [31:0] rd_value = ap_regs ? reg_rd :
                         ap_flash ? mem[ap_widx] : 32'h0000_0000;

  // Flash cells only clear bits when programmed
  wire [flash_pkg::WIDX_W-1:0] prog_idx = addr_q[flash_pkg::WIDX_MSB:flash_pkg::WIDX_LSB];
  wire prog_blk = prog_idx[flash_pkg::BLK_BIT_WIDX];
  wire ctr_blk = ctr_q[flash_pkg::BLK_BIT_WIDX];
  wire ctr_last = (ctr_q == flash_pkg::LAST_WIDX);
  wire [flash_pkg::NUM_BLOCKS-1:0] one_blk = prog_blk ? 2'b10 : 2'b01;
  wire [flash_pkg::NUM_BLOCKS-1:0] multi_blk = HWDATA_IN[flash_pkg::NUM_BLOCKS-1:0];

  // ------------------------------------------------------------
  // Command sequencer
  // ------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    ctr_d = ctr_q;
    mask_d = mask_q;
    prot_set = '0;
    prot_clr = '0;
    done_set = 1'b0;
    err_set = 1'b0;
    mem_we = 1'b0;
    mem_idx = ctr_q;
    mem_wdata = flash_pkg::ERASED_WORD;
    unique case (state_q)
      flash_pkg::S_IDLE:
      begin
        if (cmd_go)
        begin
          ctr_d = '0;
          case (cmd_code)
            flash_pkg::CMD_PROGRAM:
            begin
              if (prot[prog_blk])
                err_set = 1'b1;
              else
                state_d = flash_pkg::S_PROG;
            end
            flash_pkg::CMD_BLOCK_ERASE:
            begin
              if (prot[prog_blk])
                err_set = 1'b1;
              else
              begin
                mask_d = one_blk;
                state_d = flash_pkg::S_ERASE;
              end
            end
            flash_pkg::CMD_CHIP_ERASE:
            begin
              mask_d = ~prot;
              state_d = flash_pkg::S_ERASE;
            end
            flash_pkg::CMD_MULTI_ERASE:
            begin
              mask_d = multi_blk & ~prot;
              state_d = flash_pkg::S_ERASE;
            end
            flash_pkg::CMD_PROTECT:
            begin
              prot_set = data_q[flash_pkg::NUM_BLOCKS-1:0];
              done_set = 1'b1;
            end
            flash_pkg::CMD_UNPROTECT:
              state_d = flash_pkg::S_UNPROT;
            default:
              err_set = 1'b1;
          endcase
        end
        else if (wr_cmd)
          err_set = 1'b1;
      end
      flash_pkg::S_PROG:
      begin
        mem_we = 1'b1;
        mem_idx = prog_idx;
        mem_wdata = mem[prog_idx] & data_q;
        done_set = 1'b1;
        state_d = flash_pkg::S_IDLE;
      end
      flash_pkg::S_ERASE:
      begin
        mem_we = mask_q[ctr_blk];
        ctr_d = ctr_q + 16'h0001;
        if (ctr_last)
        begin
          done_set = 1'b1;
          state_d = flash_pkg::S_IDLE;
        end
      end
      flash_pkg::S_UNPROT:
      begin
        mem_we = 1'b1;
        ctr_d = ctr_q + 16'h0001;
        if (ctr_last)
        begin
          prot_clr = '1;
          done_set = 1'b1;
          state_d = flash_pkg::S_IDLE;
        end
      end
    endcase
    // A command while busy is refused; there is no suspend
    if (wr_cmd & busy)
      err_set = 1'b1;
  end

  // Sticky flags: a new event beats a clear in the same cycle
  wire done_d = done_set | (done_q & ~(wr_stat & HWDATA_IN[flash_pkg::ST_DONE]));
  wire err_d = err_set | (err_q & ~(wr_stat & HWDATA_IN[flash_pkg::ST_ERR]));
  wire armed_d = wr_key ? (HWDATA_IN == flash_pkg::UNLOCK_KEY) : (armed_q & ~wr_cmd);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge REF_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      state_q <= flash_pkg::S_IDLE;
      ctr_q <= '0;
      mask_q <= '0;
      done_q <= 1'b0;
      err_q <= 1'b0;
      armed_q <= 1'b0;
      toggle_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      ctr_q <= ctr_d;
      mask_q <= mask_d;
      done_q <= done_d;
      err_q <= err_d;
      armed_q <= armed_d;
      toggle_q <= busy & ~toggle_q;
    end
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      addr_q <= 32'h0000_0000;
      data_q <= 32'h0000_0000;
    end
    else
    begin
      if (wr_addr)
        addr_q <= HWDATA_IN;
      if (wr_data)
        data_q <= HWDATA_IN;
    end
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      wr_pend_q <= 1'b0;
      wr_off_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_q <= ap_write;
      wr_off_q <= ap_off;
      rdata_q <= ap_read ? rd_value : 32'h0000_0000;
    end
  end

  // Array contents are data, not control, so reset leaves them alone
  always_ff @(posedge REF_CLK_IN)
  begin
    if (mem_we)
      mem[mem_idx] <= mem_wdata;
  end

  // ------------------------------------------------------------
  // Programmer port
  // ------------------------------------------------------------
  // Runs while reset is held, so it must not sit under the system reset
  wire [flash_pkg::WIDX_W-1:0] prg_widx = PRG_ADDR_IN[flash_pkg::PRG_ADDR_W-1:1];
  wire [31:0] prg_word = mem[prg_widx];
  wire [15:0] prg_half = PRG_ADDR_IN[0] ? prg_word[31:16] : prg_word[15:0];
  wire prg_ok = programmer & PRG_RD_IN & ~lock;

  always_ff @(posedge REF_CLK_IN)
  begin
    prg_data_q <= prg_ok ? prg_half : 16'h0000;
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign HRDATA_OUT = rdata_q;
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT = 1'b0;
  assign PRG_DATA_OUT = prg_data_q;
  assign CORE_RUN_OUT = (mode == flash_pkg::MODE_SINGLE_CHIP) |
                        (mode == flash_pkg::MODE_SINGLE_BOOT);
  assign BOOT_ROM_SEL_OUT = (mode == flash_pkg::MODE_SINGLE_BOOT);
  assign FLASH_AT_VECTOR_OUT = (mode == flash_pkg::MODE_SINGLE_CHIP);
  assign PROGRAMMER_MODE_OUT = programmer;
  assign MODE_INVALID_OUT = pins_free & (mode == flash_pkg::MODE_NONE);
  assign STRAP_PINS_FREE_OUT = pins_free;
  assign PROT_OUT = prot;
  assign PRG_LOCK_OUT = lock;

endmodule

// ===== test/flash_mode_select_protect_asserts.sv
// Port-level checks for the flash mode select and protection block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module flash_mode_select_protect_asserts (
  // Clock, reset, cell init
  input wire logic REF_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic NVM_INIT_IN,
  // Bus answer
  input wire logic HREADYOUT_OUT,
  input wire logic HRESP_OUT,
  // Straps
  input wire logic BOOT_STRAP_PORT_PIN_IN,
  input wire logic TEST_STRAP_FIRST_IN,
  input wire logic TEST_STRAP_SECOND_IN,
  input wire logic MODE_STRAP_A_IN,
  input wire logic MODE_STRAP_B_IN,
  input wire logic MODE_STRAP_C_IN,
  input wire logic MODE_STRAP_D_IN,
  // Programmer port and status
  input wire logic PRG_RD_IN,
  input wire logic [15:0] PRG_DATA_OUT,
  input wire logic CORE_RUN_OUT,
  input wire logic BOOT_ROM_SEL_OUT,
  input wire logic FLASH_AT_VECTOR_OUT,
  input wire logic PROGRAMMER_MODE_OUT,
  input wire logic MODE_INVALID_OUT,
  input wire logic STRAP_PINS_FREE_OUT,
  input wire logic [flash_pkg::NUM_BLOCKS-1:0] PROT_OUT,
  input wire logic PRG_LOCK_OUT
);
  default clocking cb @(posedge REF_CLK_IN); endclocking

  zero_wait_a: assert property (HREADYOUT_OUT && !HRESP_OUT)
    else $error("bus answer not zero-wait okay");
  read_lock_a: assert property (disable iff (NVM_INIT_IN) PRG_LOCK_OUT == &PROT_OUT)
    else $error("read lock differs from both-blocks protection");
  prog_decode_a: assert property (PROGRAMMER_MODE_OUT == (SYS_RST_IN && MODE_STRAP_A_IN
    && MODE_STRAP_B_IN && !MODE_STRAP_C_IN && !MODE_STRAP_D_IN && TEST_STRAP_FIRST_IN
    && !TEST_STRAP_SECOND_IN)) else $error("programmer mode decode wrong");
  vector_pick_a: assert property (disable iff (SYS_RST_IN) $fell(SYS_RST_IN) |=>
    FLASH_AT_VECTOR_OUT == ($past(BOOT_STRAP_PORT_PIN_IN, 2) && !$past(TEST_STRAP_FIRST_IN, 2)
    && !$past(TEST_STRAP_SECOND_IN, 2))) else $error("single-chip capture wrong");
  rom_pick_a: assert property (disable iff (SYS_RST_IN) $fell(SYS_RST_IN) |=>
    BOOT_ROM_SEL_OUT == (!$past(BOOT_STRAP_PORT_PIN_IN, 2) && !$past(TEST_STRAP_FIRST_IN, 2)
    && !$past(TEST_STRAP_SECOND_IN, 2))) else $error("single-boot capture wrong");
  // Outputs settle one edge after release, so the first two edges are skipped
  mode_hold_a: assert property (disable iff (SYS_RST_IN) !$past(SYS_RST_IN) &&
    !$past(SYS_RST_IN, 2) |-> $stable(CORE_RUN_OUT) && $stable(BOOT_ROM_SEL_OUT)
    && $stable(FLASH_AT_VECTOR_OUT)) else $error("mode changed after release");
  mode_bad_a: assert property (disable iff (SYS_RST_IN) STRAP_PINS_FREE_OUT |->
    MODE_INVALID_OUT == !CORE_RUN_OUT) else $error("invalid mode flag wrong");
  rst_clear_a: assert property (SYS_RST_IN |=> !CORE_RUN_OUT && !STRAP_PINS_FREE_OUT)
    else $error("mode outputs live during reset");
  pins_free_a: assert property (disable iff (SYS_RST_IN)
    $fell(SYS_RST_IN) |=> STRAP_PINS_FREE_OUT [*3]) else $error("strap pins not freed");
  prot_keep_a: assert property (disable iff (NVM_INIT_IN) SYS_RST_IN |=> $stable(PROT_OUT))
    else $error("protection lost in reset");
  prg_quiet_a: assert property (!(PROGRAMMER_MODE_OUT && PRG_RD_IN && !PRG_LOCK_OUT)
    |=> PRG_DATA_OUT == 16'h0) else $error("programmer data without granted read");

  cover property ($fell(SYS_RST_IN) ##1 BOOT_ROM_SEL_OUT);
  cover property ($fell(SYS_RST_IN) ##1 FLASH_AT_VECTOR_OUT);
  cover property (PROGRAMMER_MODE_OUT && PRG_RD_IN);
  cover property (PROT_OUT == 2'b11);
endmodule

// ===== test/prog_station.sv
// Strap driver and external programmer read port for the flash block.
// Assumes the bench owns clock and reset and calls the tasks.
`timescale 1ns/1ps
module prog_station (
  // Clock and read data
  input wire logic clk_in,
  input wire logic [15:0] data_in,
  // Straps
  output logic boot_out,
  output logic test_first_out,
  output logic test_second_out,
  output logic [3:0] mode_strap_out,
  // Read port
  output logic rd_out,
  output logic [16:0] addr_out
);
  initial
  begin
    rd_out = 1'b0;
    addr_out = 17'h0;
    set_mode(2'd0);
  end

  // 0 single-boot, 1 single-chip, 2 programmer; don't-cares still driven
  task automatic set_mode(input logic [1:0] m);
    boot_out <= (m == 2'd1);
    test_first_out <= (m == 2'd2);
    test_second_out <= 1'b0;
    mode_strap_out <= (m == 2'd2) ? 4'h3 : 4'h0;
  endtask

  task automatic read_half(input logic [16:0] a, output logic [15:0] d);
    @(posedge clk_in);
    rd_out <= 1'b1;
    addr_out <= a;
    @(posedge clk_in);
    rd_out <= 1'b0;
    // Released lines must not look like a held address
    addr_out <= ~a;
    @(negedge clk_in);
    d = data_in;
  endtask
endmodule

// ===== test/flash_mode_select_protect_tb_top.sv
// Self-checking bench for the flash mode select and protection block.
// Assumes the package is compiled first; straps come from the partner.
`timescale 1ns/1ps
module flash_mode_select_protect_tb_top;
  logic clk, rst, nvm, hsel, hwrite, rd_ph, hready_w, boot, t1, t2, prg_rd;
  logic [1:0] htrans, prot;
  logic [3:0] strap;
  logic [16:0] prg_addr;
  logic [15:0] prg_data, rnd, h;
  logic [31:0] haddr, hwdata, hrdata, d, v, me;
  logic [31:0] exp_q[$], msk_q[$];
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t0;

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  flash_mode_select_protect dut (
    .REF_CLK_IN(clk), .SYS_RST_IN(rst), .NVM_INIT_IN(nvm), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
    .HREADY_IN(hready_w), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready_w), .HRESP_OUT(),
    .BOOT_STRAP_PORT_PIN_IN(boot), .TEST_STRAP_FIRST_IN(t1), .TEST_STRAP_SECOND_IN(t2),
    .MODE_STRAP_A_IN(strap[0]), .MODE_STRAP_B_IN(strap[1]), .MODE_STRAP_C_IN(strap[2]),
    .MODE_STRAP_D_IN(strap[3]), .PRG_RD_IN(prg_rd), .PRG_ADDR_IN(prg_addr),
    .PRG_DATA_OUT(prg_data), .CORE_RUN_OUT(), .BOOT_ROM_SEL_OUT(), .FLASH_AT_VECTOR_OUT(),
    .PROGRAMMER_MODE_OUT(), .MODE_INVALID_OUT(), .STRAP_PINS_FREE_OUT(), .PROT_OUT(prot),
    .PRG_LOCK_OUT());

  prog_station ps (.clk_in(clk), .data_in(prg_data), .boot_out(boot), .test_first_out(t1),
    .test_second_out(t2), .mode_strap_out(strap), .rd_out(prg_rd), .addr_out(prg_addr));

  function automatic logic [31:0] ra(input logic [7:0] o);
    return {flash_pkg::REG_PAGE, o};
  endfunction

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready_w !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rd_ph <= !w;
    do @(posedge clk); while (hready_w !== 1'b1);
    v = hrdata;
    rd_ph <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] o, input logic [31:0] wd);
    bus(1'b1, ra(o), wd);
  endtask

  // A zero mask notes a poll whose value steers the bench only
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic cmd(input logic [3:0] c);
    wr(flash_pkg::OFF_KEY, flash_pkg::UNLOCK_KEY);
    wr(flash_pkg::OFF_CMD, {28'h0, c});
  endtask

  task automatic do_reset(input logic [1:0] m);
    @(posedge clk);
    rst <= 1'b1;
    ps.set_mode(m);
    repeat (5) @(posedge clk);
    rst <= (m == 2'd2);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk)
    if (rd_ph === 1'b1 && hready_w === 1'b1 && msk_q.size() > 0)
    begin
      me = exp_q.pop_front();
      if (msk_q[0] != 32'h0)
        chk(hrdata & msk_q[0], me & msk_q[0]);
      void'(msk_q.pop_front());
    end

  // Erase walk dominates the run; ceiling leaves some margin
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  initial
  begin
    rst = 1'b1;
    nvm = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    rd_ph = 1'b0;
    rnd = 16'ha14d;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    nvm <= 1'b0;
    rd(ra(flash_pkg::OFF_MODE), 32'h3, 32'h3);
    rd(ra(8'h1c), 32'h0, 32'hffff_ffff);
    ps.set_mode(2'd1);
    rd(ra(flash_pkg::OFF_MODE), 32'h3, 32'h3);
    do_reset(2'd1);
    rd(ra(flash_pkg::OFF_MODE), 32'h1, 32'h3);
    wr(flash_pkg::OFF_DATA, 32'h3);
    cmd(flash_pkg::CMD_PROTECT);
    repeat (2) @(posedge clk);
    rd(ra(flash_pkg::OFF_PROT), 32'h7, 32'h7);
    wr(flash_pkg::OFF_ADDR, 32'h0);
    cmd(flash_pkg::CMD_PROGRAM);
    wr(flash_pkg::OFF_ADDR, 32'h0002_0000);
    cmd(flash_pkg::CMD_BLOCK_ERASE);
    rd(ra(flash_pkg::OFF_STATUS), 32'hc, 32'hd);
    wr(flash_pkg::OFF_STATUS, 32'hc);
    cmd(flash_pkg::CMD_UNPROTECT);
    t0 = cyc;
    rd(ra(flash_pkg::OFF_STATUS), 32'h1, 32'h1);
    chk({30'h0, prot}, 32'h3);
    cmd(flash_pkg::CMD_CHIP_ERASE);
    v = 32'h1;
    for (int i = 0; i < 40000 && v[flash_pkg::ST_BUSY] !== 1'b0; i++)
      rd(ra(flash_pkg::OFF_STATUS), 32'h0, 32'h0);
    chk({31'h0, (cyc - t0) >= 65536 && (cyc - t0) < 65560}, 32'h1);
    rd(ra(flash_pkg::OFF_STATUS), 32'hc, 32'hd);
    rd(ra(flash_pkg::OFF_PROT), 32'h0, 32'h7);
    rnd = lfsr(rnd);
    rd({14'h0, rnd, 2'b00}, flash_pkg::ERASED_WORD, 32'hffff_ffff);
    wr(flash_pkg::OFF_STATUS, 32'hc);
    d[31:16] = lfsr(rnd);
    d[15:0] = lfsr(d[31:16]);
    wr(flash_pkg::OFF_ADDR, {14'h0, rnd, 2'b00});
    wr(flash_pkg::OFF_DATA, d);
    cmd(flash_pkg::CMD_PROGRAM);
    repeat (2) @(posedge clk);
    rd(ra(flash_pkg::OFF_STATUS), 32'h4, 32'hd);
    rd({14'h0, rnd, 2'b00}, d, 32'hffff_ffff);
    do_reset(2'd2);
    ps.read_half({rnd, 1'b0}, h);
    chk({16'h0, h}, {16'h0, d[15:0]});
    ps.read_half({rnd, 1'b1}, h);
    chk({16'h0, h}, {16'h0, d[31:16]});
    // Programmer straps out of reset match no run mode
    @(posedge clk);
    rst <= 1'b0;
    rd(ra(flash_pkg::OFF_MODE), 32'h0, 32'h3);
    // Let the watcher finish its compare at the data-phase edge
    @(posedge clk);
    end_of_test();
  end
endmodule

bind flash_mode_select_protect flash_mode_select_protect_asserts chk_i (
  .REF_CLK_IN, .SYS_RST_IN, .NVM_INIT_IN, .HREADYOUT_OUT, .HRESP_OUT,
  .BOOT_STRAP_PORT_PIN_IN, .TEST_STRAP_FIRST_IN, .TEST_STRAP_SECOND_IN, .MODE_STRAP_A_IN,
  .MODE_STRAP_B_IN, .MODE_STRAP_C_IN, .MODE_STRAP_D_IN, .PRG_RD_IN, .PRG_DATA_OUT,
  .CORE_RUN_OUT, .BOOT_ROM_SEL_OUT, .FLASH_AT_VECTOR_OUT, .PROGRAMMER_MODE_OUT,
  .MODE_INVALID_OUT, .STRAP_PINS_FREE_OUT, .PROT_OUT, .PRG_LOCK_OUT);
